// *** include/sba_pkg.sv ***
/*
 * Shared constants and types of the downstream sideband control block:
 * register map, field positions, reset values, arbiter timing and states.
 * Assumes a single 100 MHz core clock and a 32-bit AHB-Lite register bus.
 */
package sba_pkg;

	// ************************************************************
	// Sizes and timing
	// ************************************************************
	localparam int NUM_MASTERS = 4;
	localparam int NUM_CLKOUT  = 5;
	localparam int GNT_GAP     = 2;
	localparam int GAP_W       = 2;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0]  CTRL_OFS = 8'h00;
	localparam logic [7:0]  STAT_OFS = 8'h04;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int CTRL_SRST_BIT   = 0;
	localparam int CTRL_CLKDIS_LSB = 8;
	localparam int CTRL_PSTATE_LSB = 16;
	localparam int PSTATE_W        = 2;
	localparam logic [1:0] PSTATE_D2    = 2'h2;
	localparam logic [1:0] PSTATE_D3HOT = 2'h3;
	localparam int STAT_SERR_BIT    = 0;
	localparam int STAT_PERR_BIT    = 1;
	localparam int STAT_GNT_LSB     = 4;
	localparam int STAT_OWN_BIT     = 8;
	localparam int STAT_EXTARB_BIT  = 9;
	localparam int STAT_DRST_BIT    = 10;
	localparam int STAT_CLKSTOP_BIT = 11;

	// ************************************************************
	// Synchronised pin vector layout
	// ************************************************************
	localparam int SYNC_W   = 12;
	localparam logic [SYNC_W-1:0] SYNC_RST = 12'hFFF;
	localparam int SY_REQ_LSB = 0;
	localparam int SY_PRST    = 4;
	localparam int SY_CFN     = 5;
	localparam int SY_BPCC    = 6;
	localparam int SY_TM      = 7;
	localparam int SY_SEN     = 8;
	localparam int SY_SERR    = 9;
	localparam int SY_FRAME   = 10;
	localparam int SY_IRDY    = 11;

	// ************************************************************
	// State encodings
	// ************************************************************
	typedef enum logic [2:0] {
		ARB_PARK = 3'b001,
		ARB_EXT  = 3'b010,
		ARB_OWN  = 3'b100
	} sba_arb_st_t;

	typedef enum logic [2:0] {
		PE_IDLE = 3'b001,
		PE_LOW  = 3'b010,
		PE_HIGH = 3'b100
	} sba_perr_st_t;

endpackage

// *** include/sba_arb_if.sv ***
/*
 * Connection between the control top and its arbiter core.
 * Assumes both ends run on the same core clock.
 */
interface sba_arb_if;
	logic                         enable;
	logic                         bus_idle;
	logic [sba_pkg::NUM_MASTERS-1:0] req;
	logic                         own_req;
	logic [sba_pkg::NUM_MASTERS-1:0] gnt;
	logic                         own_gnt;
	logic                         park;

	modport arb  (input enable, bus_idle, req, own_req,
	              output gnt, own_gnt, park);
	modport core (output enable, bus_idle, req, own_req,
	              input gnt, own_gnt, park);
endinterface

// *** rtl/sba_arb.sv ***
/*
 * Round-robin arbiter for the external downstream masters with parking.
 * Assumes synchronised, active-high requests from the control top.
 */
module sba_arb #(
	parameter int GAP = sba_pkg::GNT_GAP
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Arbiter connection
	sba_arb_if.arb   bus
);
	localparam int N = sba_pkg::NUM_MASTERS;

	if (GAP < 2 || GAP > 3) begin : g_chk
		$error("sba_arb: GAP must be 2 or 3");
	end

	typedef struct packed {
		sba_pkg::sba_arb_st_t              st;
		logic [1:0]                        cur;
		logic [1:0]                        rr;
		logic [N-1:0]                      gnt;
		logic                              own_gnt;
		logic [N-1:0][sba_pkg::GAP_W-1:0]  hold;
	} sba_arb_state_t;

	sba_arb_state_t r;
	sba_arb_state_t next_r;

	always_comb begin
		logic       found;
		logic [1:0] pick;
		logic [1:0] idx;
		logic       others;
		found  = 1'h0;
		pick   = 2'h0;
		idx    = 2'h0;
		others = 1'h0;
		next_r = r;
		for (int i = 0; i < N; i++) begin
			if (r.hold[i] != '0)
				next_r.hold[i] = r.hold[i] - 2'h1;
		end
		// Search starts after the last winner for fairness
		for (int k = 1; k <= N; k++) begin
			idx = r.rr + 2'(k);
			if (!found && bus.req[idx] && r.hold[idx] == '0) begin
				found = 1'h1;
				pick  = idx;
			end
		end
		others = |(bus.req & ~(N'(1) << r.cur));
		case (r.st)
			sba_pkg::ARB_PARK: begin
				if (bus.enable && bus.bus_idle) begin
					// R20 - own request first, one grant
					if (bus.own_req) begin
						next_r.st      = sba_pkg::ARB_OWN;
						next_r.own_gnt = 1'h1;
					// R5 - grant chosen master
					end else if (found) begin
						next_r.st  = sba_pkg::ARB_EXT;
						next_r.cur = pick;
						next_r.rr  = pick;
						next_r.gnt = N'(1) << pick;
					end
				end
			end
			sba_pkg::ARB_EXT: begin
				// Pre-empt once the owner has started and others wait
				if (!bus.enable || !bus.req[r.cur] ||
				    ((bus.own_req || others) && !bus.bus_idle)) begin
					next_r.st = sba_pkg::ARB_PARK;
					next_r.gnt = '0;
					// R6 - grant gap holdoff
					next_r.hold[r.cur] = sba_pkg::GAP_W'(GAP);
				end
			end
			sba_pkg::ARB_OWN: begin
				if (!bus.enable || !bus.own_req) begin
					next_r.st      = sba_pkg::ARB_PARK;
					next_r.own_gnt = 1'h0;
				end
			end
			default: begin
				next_r.st      = sba_pkg::ARB_PARK;
				next_r.gnt     = '0;
				next_r.own_gnt = 1'h0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			r    <= '0;
			r.st <= sba_pkg::ARB_PARK;
		end else begin
			r <= next_r;
		end
	end

	assign bus.gnt     = r.gnt;
	assign bus.own_gnt = r.own_gnt;
	assign bus.park    = (r.st == sba_pkg::ARB_PARK);

	// ************************************************************
	// Checks
	// ************************************************************
	for (genvar i = 0; i < N; i++) begin : g_gap
		property p_gnt_gap;
			@(posedge core_clk) disable iff (!nrst)
			$fell(r.gnt[i]) |-> !r.gnt[i] [*2];
		endproperty
		a_gnt_gap: assert property (p_gnt_gap) // R6
			else $error("grant reasserted within two cycles");
	end

	property p_one_owner;
		@(posedge core_clk) disable iff (!nrst)
		$onehot0({r.gnt, r.own_gnt});
	endproperty
	a_one_owner: assert property (p_one_owner) // R20
		else $error("more than one bus owner granted");

	property p_gnt_cause;
		@(posedge core_clk) disable iff (!nrst)
		(r.gnt != '0 && $past(r.gnt) == '0) |->
			($past(bus.req) & r.gnt) != '0 && $past(bus.enable);
	endproperty
	a_gnt_cause: assert property (p_gnt_cause) // R5
		else $error("grant given without request");
endmodule

// *** rtl/sba_top.sv ***
/*
 * Downstream sideband control: arbitration and parking, downstream reset,
 * parity error pin, clock outputs with power stop, scan pins, registers.
 * Assumes pins outside the core clock domain and an AHB-Lite master.
 */

// Overview of operation
// R1 - Drive parity error pin low on received data parity error.
// R2 - Drive parity error pin high one cycle before releasing it.
// R3 - Any agent may pull system error low; it is only an input.
// R4 - Masters request by pulling their request low; idle requests pulled up.
// R5 - Arbiter drives chosen master's grant low to give it the bus.
// R6 - A removed grant stays high at least two cycles.
// R7 - Idle bus with no external grant: park address, command, parity lines.
// R8 - Downstream reset low on primary reset or control reset bit.
// R9 - During downstream reset: release controls, drive zeros on data lines.
// R10 - Strap low enables internal arbiter with four external request pairs.
// R11 - Strap high: request zero is own grant, grant zero own request.
// R12 - Primary and downstream sides are timed by separate clocks.
// R13 - Five downstream clock outputs, phase locked to the source clock.
// R14 - Each clock output stops when its disable bit is set.
// R15 - Stop strap high in D2 or D3hot drives all clock outputs zero.
// R16 - Stop strap low: power state leaves clock outputs running.
// R17 - Scan test mode input low enables the scan chains.
// R18 - In scan mode, scan enable low shifts, high captures.
// R19 - Outside scan mode the scan enable pin drives logic zero.
// R20 - At most one grant, none while the device owns the bus.
module sba_top #(
	parameter int NUM_CLK = sba_pkg::NUM_CLKOUT
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// AHB-Lite register slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Forwarding core side, same clock
	input  wire logic        own_req,
	output logic             own_gnt,
	input  wire logic        rx_check,
	input  wire logic [31:0] rx_ad,
	input  wire logic [3:0]  rx_cbe,
	input  wire logic        rx_par,
	// Downstream pins in
	input  wire logic [3:0]  down_req_n,
	input  wire logic        primary_reset_n,
	input  wire logic        central_function_strap_n,
	input  wire logic        power_clock_stop_strap,
	input  wire logic        scan_test_mode_n,
	input  wire logic        scan_en_in,
	input  wire logic        down_system_error_n,
	input  wire logic        down_frame_n,
	input  wire logic        down_irdy_n,
	// Downstream pins out
	output logic [3:0]       down_grant_n,
	output logic [3:0]       down_grant_oe,
	output logic             down_reset_n,
	output logic             down_parity_error_n,
	output logic             down_parity_error_oe,
	output logic [31:0]      down_ad_out,
	output logic             down_ad_oe,
	output logic [3:0]       down_cmd_byte_enable,
	output logic             down_cmd_byte_enable_oe,
	output logic             down_parity,
	output logic             down_parity_oe,
	output logic [NUM_CLK-1:0] down_clock_outputs,
	// Scan pins
	output logic             scan_en_out,
	output logic             scan_en_oe,
	output logic             scan_shift,
	output logic             scan_capture
);
	if (NUM_CLK != sba_pkg::NUM_CLKOUT) begin : g_chk
		$error("sba_top: NUM_CLK must match the clock output count");
	end

	typedef struct packed {
		logic [sba_pkg::SYNC_W-1:0] sync1;
		logic [sba_pkg::SYNC_W-1:0] sync2;
		logic                       srst;
		logic [NUM_CLK-1:0]         clkdis;
		logic [1:0]                 pstate;
		logic                       serr_seen;
		logic                       perr_seen;
		logic                       wr_pend;
		logic [7:0]                 wr_ofs;
		logic [31:0]                hrdata;
		logic                       hreadyout;
		logic                       own_gnt;
		sba_pkg::sba_perr_st_t      perr_st;
		logic                       perr_n;
		logic                       perr_oe;
		logic [3:0]                 gnt_n;
		logic [3:0]                 gnt_oe;
		logic                       drst_n;
		logic                       drive_oe;
		logic                       clk_div;
		logic [NUM_CLK-1:0]         clkout;
		logic                       scan_en_oe;
		logic                       scan_shift;
		logic                       scan_capture;
	} sba_top_state_t;

	sba_top_state_t r;
	sba_top_state_t next_r;
	sba_arb_if      arb_if ();

	logic                       reset_req;
	logic                       int_arb;
	logic                       bus_idle;
	logic                       park;
	logic                       perr_ev;
	logic                       stop_all;
	logic                       tm_act;
	logic [sba_pkg::SYNC_W-1:0] pins;

	assign pins = {down_irdy_n, down_frame_n, down_system_error_n,
	               scan_en_in, scan_test_mode_n, power_clock_stop_strap,
	               central_function_strap_n, primary_reset_n, down_req_n};

	// R8 - reset sources
	assign reset_req = !r.sync2[sba_pkg::SY_PRST] || r.srst;
	// R10 - internal arbiter by strap
	assign int_arb  = !r.sync2[sba_pkg::SY_CFN];
	assign bus_idle = r.sync2[sba_pkg::SY_FRAME] && r.sync2[sba_pkg::SY_IRDY];
	// R7 - park only idle and ungranted
	assign park = !reset_req && bus_idle &&
	              (int_arb ? (arb_if.park && arb_if.gnt == '0)
	                       : !r.sync2[sba_pkg::SY_REQ_LSB]);
	// R1 - even parity check on received data
	assign perr_ev = rx_check && (^{rx_ad, rx_cbe, rx_par});
	// R15 - power state clock stop
	assign stop_all = r.sync2[sba_pkg::SY_BPCC] &&
	                  (r.pstate == sba_pkg::PSTATE_D2 ||
	                   r.pstate == sba_pkg::PSTATE_D3HOT);
	// R17 - scan mode active low
	assign tm_act = !r.sync2[sba_pkg::SY_TM];

	assign arb_if.enable   = int_arb && !reset_req;
	assign arb_if.bus_idle = bus_idle;
	// R4 - requests are active low at the pins
	assign arb_if.req      = ~r.sync2[sba_pkg::SY_REQ_LSB +: 4];
	assign arb_if.own_req  = own_req;

	sba_arb u_arb (
		.core_clk (core_clk),
		.nrst     (nrst),
		.bus      (arb_if.arb)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic       acc;
		logic [7:0] ofs;
		logic       clr_serr;
		logic       clr_perr;
		acc      = hsel && htrans[1] && hready;
		ofs      = haddr[7:0];
		clr_serr = 1'h0;
		clr_perr = 1'h0;
		next_r   = r;
		// Pins pass two flops before any use
		// R12 - foreign clock inputs synchronised
		next_r.sync1     = pins;
		next_r.sync2     = r.sync1;
		next_r.hreadyout = 1'h1;

		// Register writes land in the data phase
		if (r.wr_pend && r.wr_ofs == sba_pkg::CTRL_OFS) begin
			next_r.srst   = hwdata[sba_pkg::CTRL_SRST_BIT];
			next_r.clkdis = hwdata[sba_pkg::CTRL_CLKDIS_LSB +: NUM_CLK];
			next_r.pstate = hwdata[sba_pkg::CTRL_PSTATE_LSB +:
			                       sba_pkg::PSTATE_W];
		end
		if (r.wr_pend && r.wr_ofs == sba_pkg::STAT_OFS) begin
			clr_serr = hwdata[sba_pkg::STAT_SERR_BIT];
			clr_perr = hwdata[sba_pkg::STAT_PERR_BIT];
		end
		next_r.wr_pend = acc && hwrite;
		next_r.wr_ofs  = ofs;
		// R3 - system error is observed only
		next_r.serr_seen = (r.serr_seen && !clr_serr) ||
		                   !r.sync2[sba_pkg::SY_SERR];
		next_r.perr_seen = (r.perr_seen && !clr_perr) || perr_ev;

		// Control and sticky bits read from next values so a write is seen at once
		if (acc && !hwrite) begin
			next_r.hrdata = '0;
			if (ofs == sba_pkg::CTRL_OFS) begin
				next_r.hrdata[sba_pkg::CTRL_SRST_BIT] = next_r.srst;
				next_r.hrdata[sba_pkg::CTRL_CLKDIS_LSB +: NUM_CLK] =
					next_r.clkdis;
				next_r.hrdata[sba_pkg::CTRL_PSTATE_LSB +:
				              sba_pkg::PSTATE_W] = next_r.pstate;
			end else if (ofs == sba_pkg::STAT_OFS) begin
				next_r.hrdata[sba_pkg::STAT_SERR_BIT] = next_r.serr_seen;
				next_r.hrdata[sba_pkg::STAT_PERR_BIT] = next_r.perr_seen;
				next_r.hrdata[sba_pkg::STAT_GNT_LSB +: 4] = arb_if.gnt;
				next_r.hrdata[sba_pkg::STAT_OWN_BIT] = r.own_gnt;
				next_r.hrdata[sba_pkg::STAT_EXTARB_BIT] = !int_arb;
				next_r.hrdata[sba_pkg::STAT_DRST_BIT] = reset_req;
				next_r.hrdata[sba_pkg::STAT_CLKSTOP_BIT] = stop_all;
			end
		end

		// R8 - downstream reset output
		next_r.drst_n = !reset_req;
		// R7 - park drive; R9 - zeros driven during reset
		next_r.drive_oe = reset_req || park;

		// R10 - four external pairs; R11 - pair zero reused
		if (int_arb) begin
			next_r.gnt_n   = ~arb_if.gnt;
			next_r.gnt_oe  = 4'hF;
			next_r.own_gnt = arb_if.own_gnt;
		end else begin
			next_r.gnt_n   = {3'h7, !own_req};
			next_r.gnt_oe  = 4'h1;
			next_r.own_gnt = !r.sync2[sba_pkg::SY_REQ_LSB];
		end
		// R9 - controls released in reset
		if (reset_req) begin
			next_r.gnt_oe  = 4'h0;
			next_r.gnt_n   = 4'hF;
			next_r.own_gnt = 1'h0;
		end

		// R1 - error pin sequence; R2 - high before release
		case (r.perr_st)
			sba_pkg::PE_IDLE: begin
				if (perr_ev) begin
					next_r.perr_st = sba_pkg::PE_LOW;
					next_r.perr_n  = 1'h0;
					next_r.perr_oe = 1'h1;
				end
			end
			sba_pkg::PE_LOW, sba_pkg::PE_HIGH: begin
				next_r.perr_oe = 1'h1;
				if (perr_ev) begin
					next_r.perr_st = sba_pkg::PE_LOW;
					next_r.perr_n  = 1'h0;
				end else if (r.perr_st == sba_pkg::PE_LOW) begin
					next_r.perr_st = sba_pkg::PE_HIGH;
					next_r.perr_n  = 1'h1;
				end else begin
					next_r.perr_st = sba_pkg::PE_IDLE;
					next_r.perr_oe = 1'h0;
				end
			end
			default: begin
				next_r.perr_st = sba_pkg::PE_IDLE;
				next_r.perr_n  = 1'h1;
				next_r.perr_oe = 1'h0;
			end
		endcase
		if (reset_req) begin
			next_r.perr_st = sba_pkg::PE_IDLE;
			next_r.perr_n  = 1'h1;
			next_r.perr_oe = 1'h0;
		end

		// R13 - all outputs follow one divider, so they stay in phase
		next_r.clk_div = !r.clk_div;
		for (int i = 0; i < NUM_CLK; i++) begin
			// R14 - per-output stop; R16 - strap low ignores power state
			next_r.clkout[i] = (!r.clkdis[i] && !stop_all) ?
			                   !r.clk_div : 1'h0;
		end

		// R18 - shift or capture; R19 - pin is output outside scan
		next_r.scan_en_oe   = !tm_act;
		next_r.scan_shift   = tm_act && !r.sync2[sba_pkg::SY_SEN];
		next_r.scan_capture = tm_act && r.sync2[sba_pkg::SY_SEN];
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			r           <= '0;
			r.sync1     <= sba_pkg::SYNC_RST;
			r.sync2     <= sba_pkg::SYNC_RST;
			r.hreadyout <= 1'h1;
			r.perr_st   <= sba_pkg::PE_IDLE;
			r.perr_n    <= 1'h1;
			r.gnt_n     <= 4'hF;
			// R9 - zeros driven while held in reset
			r.drive_oe  <= 1'h1;
			// R19 - pins look out of scan mode in reset
			r.scan_en_oe <= 1'h1;
		end else begin
			r <= next_r;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign hreadyout               = r.hreadyout;
	assign hrdata                  = r.hrdata;
	assign hresp                   = 1'h0;
	assign own_gnt                 = r.own_gnt;
	assign down_grant_n            = r.gnt_n;
	assign down_grant_oe           = r.gnt_oe;
	assign down_reset_n            = r.drst_n;
	assign down_parity_error_n     = r.perr_n;
	assign down_parity_error_oe    = r.perr_oe;
	// Parked and reset value is all zero, which has even parity
	assign down_ad_out             = 32'h0000_0000;
	assign down_ad_oe              = r.drive_oe;
	assign down_cmd_byte_enable    = 4'h0;
	assign down_cmd_byte_enable_oe = r.drive_oe;
	assign down_parity             = 1'h0;
	assign down_parity_oe          = r.drive_oe;
	assign down_clock_outputs      = r.clkout;
	assign scan_en_out             = 1'h0;
	assign scan_en_oe              = r.scan_en_oe;
	assign scan_shift              = r.scan_shift;
	assign scan_capture            = r.scan_capture;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_perr_low;
		perr_ev && !reset_req |=> !down_parity_error_n &&
			down_parity_error_oe;
	endproperty
	a_perr_low: assert property (p_perr_low) // R1
		else $error("parity error pin not driven low");

	property p_perr_release;
		$fell(down_parity_error_oe) && $past(nrst) && !$past(reset_req) |->
			$past(down_parity_error_n) && $past(down_parity_error_oe);
	endproperty
	a_perr_release: assert property (p_perr_release) // R2
		else $error("parity error pin released without high cycle");

	property p_park;
		park |=> down_ad_oe && down_cmd_byte_enable_oe && down_parity_oe;
	endproperty
	a_park: assert property (p_park) // R7
		else $error("idle bus not parked");

	property p_drst;
		reset_req |=> !down_reset_n ##1 (!down_reset_n || !reset_req);
	endproperty
	a_drst: assert property (p_drst) // R8
		else $error("downstream reset not asserted");

	property p_reset_pins;
		!down_reset_n |-> down_grant_oe == 4'h0 && !down_parity_error_oe
			&& down_ad_oe && down_cmd_byte_enable_oe && down_parity_oe;
	endproperty
	a_reset_pins: assert property (p_reset_pins) // R9
		else $error("pins wrong during downstream reset");

	property p_int_arb;
		int_arb && !reset_req |=> down_grant_n == ~$past(arb_if.gnt);
	endproperty
	a_int_arb: assert property (p_int_arb) // R10
		else $error("grant pins do not follow internal arbiter");

	property p_ext_arb;
		!int_arb && !reset_req |=> down_grant_n[0] == !$past(own_req)
			&& own_gnt == !$past(r.sync2[sba_pkg::SY_REQ_LSB]);
	endproperty
	a_ext_arb: assert property (p_ext_arb) // R11
		else $error("external arbiter pairing wrong");

	property p_clk_dis;
		1'h1 |=> (down_clock_outputs & $past(r.clkdis)) == '0;
	endproperty
	a_clk_dis: assert property (p_clk_dis) // R14
		else $error("disabled clock output running");

	property p_clk_stop;
		stop_all |=> down_clock_outputs == '0;
	endproperty
	a_clk_stop: assert property (p_clk_stop) // R15
		else $error("clocks not stopped in low power state");

	property p_clk_run;
		!stop_all && r.clkdis == '0 |=>
			down_clock_outputs == {NUM_CLK{r.clk_div}};
	endproperty
	a_clk_run: assert property (p_clk_run) // R16
		else $error("enabled clock outputs not toggling");

	property p_scan;
		tm_act |=> scan_shift == !$past(r.sync2[sba_pkg::SY_SEN]) &&
			scan_capture == $past(r.sync2[sba_pkg::SY_SEN]) && !scan_en_oe;
	endproperty
	a_scan: assert property (p_scan) // R18
		else $error("scan shift or capture select wrong");

	property p_scan_off;
		!tm_act |=> scan_en_oe && !scan_en_out && !scan_shift
			&& !scan_capture;
	endproperty
	a_scan_off: assert property (p_scan_off) // R19
		else $error("scan enable pin not driving zero");
endmodule

// *** verif/sba_masters.sv ***
/* External downstream masters model.
   Assumes pull-ups keep unused request pins high, bus left idle. */
module sba_masters (
	// Control
	input  wire logic       core_clk,
	input  wire logic [3:0] want,
	// Pins
	output logic [3:0]      req_n,
	output logic            frame_n,
	output logic            irdy_n
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge core_clk) req_n <= ~want;
	// Idle bus so parking shows
	assign frame_n = 1'b1;
	assign irdy_n  = 1'b1;
endmodule

// *** verif/tb.sv ***
/* Self-checking bench of the downstream sideband control.
   Assumes the masters model and a 100 MHz core clock. */
`define CHK(n,e,a) begin checks++; if ((a) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, nrst = 0, hwrite = 0, own_req = 0, rx_check = 0;
	logic primary_reset_n = 1, central_function_strap_n = 0;
	logic down_system_error_n = 1;
	logic power_clock_stop_strap = 0, scan_test_mode_n = 1, scan_en_in = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, rx_ad = 0, rd;
	logic [3:0]  want = 0;
	logic [4:0]  o;
	wire hreadyout, hresp, own_gnt, down_reset_n, down_parity_error_n;
	wire down_parity_error_oe, down_ad_oe, down_cmd_byte_enable_oe;
	wire down_parity, down_parity_oe, scan_en_out, scan_en_oe;
	wire scan_shift, scan_capture, down_frame_n, down_irdy_n;
	wire [31:0] hrdata, down_ad_out;
	wire [3:0]  down_req_n, down_grant_n, down_grant_oe, down_cmd_byte_enable;
	wire [4:0]  down_clock_outputs;
	int fail_count, checks;

	sba_top DUT (.core_clk, .nrst, .hsel(1'b1), .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hreadyout, .hrdata, .hresp, .own_req, .own_gnt, .rx_check, .rx_ad,
		.rx_cbe(4'h0), .rx_par(1'b0), .down_req_n, .primary_reset_n,
		.central_function_strap_n, .power_clock_stop_strap,
		.scan_test_mode_n, .scan_en_in, .down_system_error_n,
		.down_frame_n, .down_irdy_n, .down_grant_n, .down_grant_oe,
		.down_reset_n, .down_parity_error_n, .down_parity_error_oe,
		.down_ad_out, .down_ad_oe, .down_cmd_byte_enable,
		.down_cmd_byte_enable_oe, .down_parity, .down_parity_oe,
		.down_clock_outputs, .scan_en_out, .scan_en_oe, .scan_shift,
		.scan_capture);
	sba_masters M (.core_clk, .want, .req_n(down_req_n),
		.frame_n(down_frame_n), .irdy_n(down_irdy_n));

	always #5 core_clk = ~core_clk;

	task automatic cyc(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Single AHB-Lite transfer, waits on hreadyout
	task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
		@(posedge core_clk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Halved clock toggles each cycle, so four samples show it
	task automatic clk_or();
		o = 0;
		cyc(4);
		repeat (4) begin
			cyc(1);
			o |= down_clock_outputs;
		end
	endtask
	task automatic t_clk();
		bus(1, 32'h0, 32'h0000_1500);
		bus(0, 32'h0, 32'h0);
		`CHK("ctrl", 32'h0000_1500, rd)
		clk_or();
		`CHK("clk dis", 5'h0A, o)
		bus(1, 32'h0, 32'h0003_0000);
		@(posedge core_clk) power_clock_stop_strap <= 1'b1;
		clk_or();
		`CHK("clk stop", 5'h00, o)
		@(posedge core_clk) power_clock_stop_strap <= 1'b0;
		clk_or();
		`CHK("clk run", 5'h1F, o)
		bus(0, 32'h8, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		bus(1, 32'h0, 32'h0);
		$display("clocks done");
	endtask
	task automatic t_rst();
		bus(1, 32'h0, 32'h1);
		cyc(2);
		`CHK("drst", 1'b0, down_reset_n)
		`CHK("zeros", 38'h20_0000_0000, {down_ad_oe, down_ad_out, down_cmd_byte_enable, down_parity})
		`CHK("gnt oe", 4'h0, down_grant_oe)
		bus(1, 32'h0, 32'h0);
		@(posedge core_clk) primary_reset_n <= 1'b0;
		cyc(4);
		`CHK("prst", 1'b0, down_reset_n)
		@(posedge core_clk) primary_reset_n <= 1'b1;
		cyc(4);
		`CHK("drst off", 1'b1, down_reset_n)
		`CHK("park", 1'b1, down_ad_oe)
		$display("reset done");
	endtask
	task automatic t_perr();
		@(posedge core_clk) rx_ad <= 32'h1;
		rx_check <= 1'b1;
		@(posedge core_clk) rx_check <= 1'b0;
		#1;
		repeat (3) if (down_parity_error_n !== 1'b0) cyc(1);
		`CHK("perr", 2'b01, {down_parity_error_n, down_parity_error_oe})
		cyc(1);
		`CHK("perr hi", 2'b11, {down_parity_error_n, down_parity_error_oe})
		cyc(1);
		`CHK("perr off", 1'b0, down_parity_error_oe)
		@(posedge core_clk) down_system_error_n <= 1'b0;
		@(posedge core_clk) down_system_error_n <= 1'b1;
		bus(0, 32'h4, 32'h0);
		`CHK("sticky", 2'b11, rd[1:0])
		bus(1, 32'h4, 32'h3);
		bus(0, 32'h4, 32'h0);
		`CHK("cleared", 2'b00, rd[1:0])
		$display("parity done");
	endtask
	task automatic t_arb();
		int hi = 0;
		@(posedge core_clk) want <= 4'h2;
		repeat (8) if (down_grant_n !== 4'hD) cyc(1);
		`CHK("gnt", 4'hD, down_grant_n)
		`CHK("no park", 1'b0, down_ad_oe)
		// One-cycle release would regrant at once without holdoff
		@(posedge core_clk) want <= 4'h0;
		@(posedge core_clk) want <= 4'h2;
		repeat (8) if (down_grant_n !== 4'hF) cyc(1);
		repeat (8) if (down_grant_n[1] !== 1'b0) begin
			hi++;
			cyc(1);
		end
		`CHK("gap", 1'b1, hi >= 2)
		`CHK("regrant", 4'hD, down_grant_n)
		@(posedge core_clk) want <= 4'h0;
		own_req <= 1'b1;
		repeat (12) if (own_gnt !== 1'b1) cyc(1);
		`CHK("own", 5'h1F, {own_gnt, down_grant_n})
		@(posedge core_clk) central_function_strap_n <= 1'b1;
		want <= 4'h1;
		cyc(6);
		`CHK("ext", 2'b10, {own_gnt, down_grant_n[0]})
		@(posedge core_clk) central_function_strap_n <= 1'b0;
		own_req <= 1'b0;
		want <= 4'h0;
		$display("arbiter done");
	endtask
	task automatic t_scan();
		`CHK("scan off", 2'b10, {scan_en_oe, scan_en_out})
		@(posedge core_clk) scan_test_mode_n <= 1'b0;
		cyc(4);
		`CHK("shift", 3'b010, {scan_en_oe, scan_shift, scan_capture})
		@(posedge core_clk) scan_en_in <= 1'b1;
		cyc(4);
		`CHK("capture", 3'b001, {scan_en_oe, scan_shift, scan_capture})
		$display("scan done");
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		t_clk();
		t_rst();
		t_perr();
		t_arb();
		t_scan();
		conclude();
	end
	initial begin
		#20000;
		fail_count++;
		conclude();
	end
endmodule
